// *** design/gpio_pin_cell.sv ***
// One general-purpose pin: input synchroniser, drive style, override and event detect.
`timescale 1ns/10ps
module gpio_pin_cell (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_in,
  input wire logic dir_out,
  input wire logic open_drain,
  input wire logic data_out,
  input wire logic event_sel,
  input wire logic override_en,
  input wire logic override_val,
  output logic level,
  output logic pin_event,
  output logic pin_out,
  output logic pin_oe
);

  logic sync_first; // First stage, read only by the second stage.
  logic level_prev; // Last synchronised level, for edge detection.

  // Two-stage synchroniser on the pin level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_first <= 1'b0;
      level <= 1'b0;
      level_prev <= 1'b0;
    end else begin
      sync_first <= pin_in;
      level <= sync_first;
      level_prev <= level;
    end
  end

  // Any edge on an input pin in event mode is one event.
  assign pin_event = !dir_out && event_sel && (level != level_prev);

  // Pin drivers come from flops so the pad never sees a glitch.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (override_en) begin
      // Override sources always drive push-pull.
      pin_out <= override_val;
      pin_oe <= 1'b1;
    end else if (!dir_out) begin
      // Input or event source: pad released.
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (open_drain) begin
      // Open drain pulls low only; high is left to the pull-up.
      pin_out <= 1'b0;
      pin_oe <= !data_out;
    end else begin
      // Push-pull drives both levels.
      pin_out <= data_out;
      pin_oe <= 1'b1;
    end
  end

endmodule // gpio_pin_cell

// *** design/uart_pin_mux.sv ***
// Pin function multiplexer for the transceiver side of a four channel UART.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/10ps

// Contract
// - GPIO pins are input, push-pull or open-drain
// - GPIO pins may raise event interrupts
// - Sync control bit 7 puts reference clock out
// - Upper timer bit 7 puts timer out
// - Line control bit sets request-to-send level
// - Clock source bit 7 puts clock on RTS
// - Clear-to-send input is flow status from peer
// - Each channel has own transmit and receive pin
module uart_pin_mux (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  input wire logic [15:0] GPIO_IN,
  output logic [15:0] GPIO_OUT,
  output logic [15:0] GPIO_OE,
  input wire logic TIMER_OUT,
  input wire logic [3:0] UART_CLK_OUT,
  input wire logic [3:0] UART_TXD,
  output logic [3:0] UART_RXD,
  output logic [3:0] UART_CTS_N,
  output logic [3:0] SERIAL_OUT,
  input wire logic [3:0] SERIAL_IN,
  output logic [3:0] RTS_N,
  input wire logic [3:0] CTS_N
);

  // Software-owned configuration.
  logic [15:0] gpio_dir; // One means output.
  logic [15:0] gpio_od; // One means open drain when output.
  logic [15:0] gpio_data; // Output value per pin.
  logic [15:0] gpio_event_sel; // One makes an input pin an event source.
  logic [7:0] tx_sync_control; // Bit 7 routes the reference clock.
  logic [7:0] timer_control_upper; // Bit 7 routes the timer output.
  logic [7:0] clock_source_select [4]; // Bit 7 routes a clock to RTS.
  logic [7:0] line_control [4]; // Carries the RTS force bit.
  logic [19:0] int_status; // Sticky event bits.
  logic [19:0] int_enable; // Mask onto the interrupt line.

  // Pin-side state.
  // Receive and clear-to-send stages reset to the idle line level.
  logic [15:0] gpio_level; // Synchronised pin levels.
  logic [15:0] gpio_event; // One-cycle pin event pulses.
  logic [3:0] rx_first; // First synchroniser stage for receive pins.
  logic [3:0] cts_first; // First synchroniser stage for clear-to-send.
  logic [3:0] cts_prev; // Previous synchronised clear-to-send level.
  logic [3:0] cts_event; // Clear-to-send change pulses.
  logic [19:0] events; // All event sources in status layout.

  // Reference clock divider; eight bits leave room for slower half periods.
  // The output is a plain data bit, so the block still runs on one clock only.
  logic [7:0] ref_count; // Cycles counted in the current half period.
  logic ref_tick; // One-cycle enable at the end of each half period.
  logic ref_clk; // Reference clock level handed to the override pins.

  // Bus decode.
  // The slave never stalls, so the write strobe needs no ready term.
  logic setup_phase; // First cycle of a transfer.
  logic wr_en; // Write in its access cycle.
  logic [31:0] next_rdata; // Read word for the current address.
  logic next_err; // Address matches no register.
  logic [15:0] override_en; // Pin taken by an override source.
  logic [15:0] override_val; // Level that the override source drives.

  // The bus answers in its first access cycle; read data are latched at setup.
  // Unmapped addresses still complete at once, with PSLVERR raised.
  assign setup_phase = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign PREADY = 1'b1;

  // Combinational read mux with a decode error for unmapped addresses.
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (PADDR)
      uart_pin_mux_pkg::ADDR_GPIO_DIR: next_rdata[15:0] = gpio_dir;
      uart_pin_mux_pkg::ADDR_GPIO_OD: next_rdata[15:0] = gpio_od;
      uart_pin_mux_pkg::ADDR_GPIO_DATA: next_rdata[15:0] = gpio_data;
      uart_pin_mux_pkg::ADDR_GPIO_LEVEL: next_rdata[15:0] = gpio_level;
      uart_pin_mux_pkg::ADDR_GPIO_EVENT_SEL: next_rdata[15:0] = gpio_event_sel;
      uart_pin_mux_pkg::ADDR_INT_STATUS: next_rdata[19:0] = int_status;
      // The clear register is write-only and reads as zero.
      uart_pin_mux_pkg::ADDR_INT_CLEAR: next_rdata = 32'h0000_0000;
      uart_pin_mux_pkg::ADDR_INT_ENABLE: next_rdata[19:0] = int_enable;
      uart_pin_mux_pkg::ADDR_TX_SYNC_CONTROL: next_rdata[7:0] = tx_sync_control;
      uart_pin_mux_pkg::ADDR_TIMER_CONTROL_UPPER: next_rdata[7:0] = timer_control_upper;
      uart_pin_mux_pkg::ADDR_FLOW_STATUS: begin
        // Low nibble is clear-to-send, next nibble is the RTS pin level.
        next_rdata[3:0] = UART_CTS_N;
        next_rdata[uart_pin_mux_pkg::FLOW_RTS_LSB +: 4] = RTS_N;
      end
      default: begin
        // Per-channel registers sit at a fixed stride and are matched in a loop.
        // Anything left over is unmapped and answers with an error.
        next_err = 1'b1;
        for (int ch = 0; ch < uart_pin_mux_pkg::CHANNELS; ch++) begin
          if (PADDR == 8'(uart_pin_mux_pkg::ADDR_CLOCK_SOURCE_SELECT0
              + 8'(ch) * uart_pin_mux_pkg::ADDR_CHANNEL_STRIDE)) begin
            next_rdata[7:0] = clock_source_select[ch];
            next_err = 1'b0;
          end
          if (PADDR == 8'(uart_pin_mux_pkg::ADDR_LINE_CONTROL0
              + 8'(ch) * uart_pin_mux_pkg::ADDR_CHANNEL_STRIDE)) begin
            next_rdata[7:0] = line_control[ch];
            next_err = 1'b0;
          end
        end
      end
    endcase
  end

  // Read data and error are held in flops from the setup cycle.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup_phase) begin
      // Writes load zero so old read data never linger on the bus.
      PRDATA <= PWRITE ? 32'h0000_0000 : next_rdata;
      PSLVERR <= next_err;
    end
  end

  // GPIO configuration registers.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      gpio_dir <= uart_pin_mux_pkg::RESET_GPIO;
      gpio_od <= uart_pin_mux_pkg::RESET_GPIO;
      gpio_data <= uart_pin_mux_pkg::RESET_GPIO;
      gpio_event_sel <= uart_pin_mux_pkg::RESET_GPIO;
    end else if (wr_en) begin
      // Direction and drive style reach the pins one cycle after the write.
      if (PADDR == uart_pin_mux_pkg::ADDR_GPIO_DIR) begin
        gpio_dir <= PWDATA[15:0];
      end
      if (PADDR == uart_pin_mux_pkg::ADDR_GPIO_OD) begin
        gpio_od <= PWDATA[15:0];
      end
      if (PADDR == uart_pin_mux_pkg::ADDR_GPIO_DATA) begin
        gpio_data <= PWDATA[15:0];
      end
      if (PADDR == uart_pin_mux_pkg::ADDR_GPIO_EVENT_SEL) begin
        gpio_event_sel <= PWDATA[15:0];
      end
    end
  end

  // Override control registers for the general pins.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_sync_control <= uart_pin_mux_pkg::RESET_BYTE;
      timer_control_upper <= uart_pin_mux_pkg::RESET_BYTE;
    end else if (wr_en) begin
      // Only bit 7 acts here; the other bits are stored for software.
      if (PADDR == uart_pin_mux_pkg::ADDR_TX_SYNC_CONTROL) begin
        tx_sync_control <= PWDATA[7:0];
      end
      if (PADDR == uart_pin_mux_pkg::ADDR_TIMER_CONTROL_UPPER) begin
        timer_control_upper <= PWDATA[7:0];
      end
    end
  end

  // Per-channel clock source and line control registers.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      // Every channel starts with its flow pin under line control.
      for (int ch = 0; ch < uart_pin_mux_pkg::CHANNELS; ch++) begin
        clock_source_select[ch] <= uart_pin_mux_pkg::RESET_BYTE;
        line_control[ch] <= uart_pin_mux_pkg::RESET_BYTE;
      end
    end else if (wr_en) begin
      // Each channel decodes its own two addresses.
      for (int ch = 0; ch < uart_pin_mux_pkg::CHANNELS; ch++) begin
        if (PADDR == 8'(uart_pin_mux_pkg::ADDR_CLOCK_SOURCE_SELECT0
            + 8'(ch) * uart_pin_mux_pkg::ADDR_CHANNEL_STRIDE)) begin
          clock_source_select[ch] <= PWDATA[7:0];
        end
        if (PADDR == 8'(uart_pin_mux_pkg::ADDR_LINE_CONTROL0
            + 8'(ch) * uart_pin_mux_pkg::ADDR_CHANNEL_STRIDE)) begin
          line_control[ch] <= PWDATA[7:0];
        end
      end
    end
  end

  // Enable pulse from the divider: high for one cycle per half period.
  assign ref_tick = (ref_count == uart_pin_mux_pkg::REF_HALF_LAST);

  // Reference clock made by toggling on the enable pulse.
  // It runs from reset, so a pin switched to it may start with a short first phase.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ref_count <= 8'h00;
      ref_clk <= 1'b0;
    end else if (ref_tick) begin
      // Wrap the count and flip the output level.
      ref_count <= 8'h00;
      ref_clk <= !ref_clk;
    end else begin
      ref_count <= ref_count + 8'h01;
    end
  end

  // Override selection per pin; a clear bit hands the pin back to GPIO.
  // The reference clock is tested first; the two pin masks do not overlap.
  always_comb begin
    for (int p = 0; p < uart_pin_mux_pkg::PINS; p++) begin
      override_en[p] = 1'b0;
      override_val[p] = 1'b0;
      if (uart_pin_mux_pkg::REF_CLOCK_PINS[p]
          && tx_sync_control[uart_pin_mux_pkg::OVERRIDE_BIT]) begin
        override_en[p] = 1'b1;
        override_val[p] = ref_clk;
      end else if (uart_pin_mux_pkg::TIMER_PINS[p]
          && timer_control_upper[uart_pin_mux_pkg::OVERRIDE_BIT]) begin
        override_en[p] = 1'b1;
        override_val[p] = TIMER_OUT;
      end
    end
  end

  // One cell per general pin.
  // Each cell has its own synchroniser and edge detector, so pins stay independent.
  for (genvar p = 0; p < uart_pin_mux_pkg::PINS; p++) begin : g_pin
    gpio_pin_cell u_cell (
      .clk(SYS_CLK),
      .rst_n(RESETN),
      .pin_in(GPIO_IN[p]),
      .dir_out(gpio_dir[p]),
      .open_drain(gpio_od[p]),
      .data_out(gpio_data[p]),
      .event_sel(gpio_event_sel[p]),
      .override_en(override_en[p]),
      .override_val(override_val[p]),
      .level(gpio_level[p]),
      .pin_event(gpio_event[p]),
      .pin_out(GPIO_OUT[p]),
      .pin_oe(GPIO_OE[p])
    );
  end

  // Receive and clear-to-send pins come from the line, so they are synchronised.
  // The stages reset to the idle high level, so no false change follows reset.
  // Only the second stage is read by other logic.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_first <= 4'hF;
      UART_RXD <= 4'hF;
      cts_first <= 4'hF;
      UART_CTS_N <= 4'hF;
      cts_prev <= 4'hF;
    end else begin
      rx_first <= SERIAL_IN;
      UART_RXD <= rx_first;
      cts_first <= CTS_N;
      UART_CTS_N <= cts_first;
      cts_prev <= UART_CTS_N;
    end
  end

  // A change of clear-to-send is reported as an event.
  assign cts_event = UART_CTS_N ^ cts_prev;

  // Transmit data go straight out through a retiming flop.
  // The flop costs one cycle of latency but keeps the pad free of logic glitches.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SERIAL_OUT <= 4'hF;
    end else begin
      SERIAL_OUT <= UART_TXD;
    end
  end

  // Request-to-send: forced level, or the channel clock when selected.
  // Both sources pass the same flop, so a source switch cannot glitch the pin.
  // A clock on the pin is therefore one cycle behind the channel's divider.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RTS_N <= 4'hF;
    end else begin
      for (int ch = 0; ch < uart_pin_mux_pkg::CHANNELS; ch++) begin
        if (clock_source_select[ch][uart_pin_mux_pkg::OVERRIDE_BIT]) begin
          RTS_N[ch] <= UART_CLK_OUT[ch];
        end else begin
          // Force bit one asserts the pin, which is active low.
          RTS_N[ch] <= !line_control[ch][uart_pin_mux_pkg::RTS_FORCE_BIT];
        end
      end
    end
  end

  // Pin events fill the low 16 bits of the status word, flow changes sit above.
  assign events[15:0] = gpio_event;
  assign events[uart_pin_mux_pkg::CTS_EVENT_LSB +: 4] = cts_event;

  // Sticky status; a new event in the clear cycle wins so none is lost.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      int_status <= uart_pin_mux_pkg::RESET_INT;
    end else if (wr_en && PADDR == uart_pin_mux_pkg::ADDR_INT_CLEAR) begin
      // Write one to clear; bits written as zero are left alone.
      int_status <= (int_status & ~PWDATA[19:0]) | events;
    end else begin
      // Without a clear, status only collects new events.
      int_status <= int_status | events;
    end
  end

  // Interrupt enable register.
  // Masking stops only the line; status keeps collecting while masked.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      int_enable <= uart_pin_mux_pkg::RESET_INT;
    end else if (wr_en && PADDR == uart_pin_mux_pkg::ADDR_INT_ENABLE) begin
      int_enable <= PWDATA[19:0];
    end
  end

  // Level interrupt, registered so it cannot glitch.
  // The registered line lags the status bits by one cycle.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(int_status & int_enable);
    end
  end

endmodule // uart_pin_mux

// *** design/uart_pin_mux_pkg.sv ***
// Shared constants for the quad serial pin function multiplexer.
package uart_pin_mux_pkg;

  // Pin and channel counts.
  localparam int PINS = 16;
  localparam int CHANNELS = 4;

  // Register byte addresses on the APB bus.
  localparam logic [7:0] ADDR_GPIO_DIR = 8'h00;
  localparam logic [7:0] ADDR_GPIO_OD = 8'h04;
  localparam logic [7:0] ADDR_GPIO_DATA = 8'h08;
  localparam logic [7:0] ADDR_GPIO_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_GPIO_EVENT_SEL = 8'h10;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h14;
  localparam logic [7:0] ADDR_INT_CLEAR = 8'h18;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h1C;
  localparam logic [7:0] ADDR_TX_SYNC_CONTROL = 8'h20;
  localparam logic [7:0] ADDR_TIMER_CONTROL_UPPER = 8'h24;
  localparam logic [7:0] ADDR_FLOW_STATUS = 8'h28;
  localparam logic [7:0] ADDR_CLOCK_SOURCE_SELECT0 = 8'h30;
  localparam logic [7:0] ADDR_LINE_CONTROL0 = 8'h40;
  localparam logic [7:0] ADDR_CHANNEL_STRIDE = 8'h04;

  // Field positions.
  localparam int OVERRIDE_BIT = 7;
  localparam int RTS_FORCE_BIT = 1;
  localparam int CTS_EVENT_LSB = 16;
  localparam int FLOW_RTS_LSB = 4;

  // Pins that take an override source.
  localparam logic [15:0] REF_CLOCK_PINS = 16'h1110;
  localparam logic [15:0] TIMER_PINS = 16'h2220;

  // Reset values.
  localparam logic [15:0] RESET_GPIO = 16'h0000;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [19:0] RESET_INT = 20'h0_0000;

  // Reference clock output: one half period in nanoseconds and in cycles.
  localparam int SYS_CLK_PERIOD_NS = 20;
  localparam int REF_HALF_PERIOD_NS = 40;
  localparam int REF_HALF_CYCLES = (REF_HALF_PERIOD_NS + SYS_CLK_PERIOD_NS - 1)
      / SYS_CLK_PERIOD_NS;
  localparam logic [7:0] REF_HALF_LAST = 8'(REF_HALF_CYCLES - 1);

endpackage

// *** verification/serial_peer.sv ***
// Far side model: line transceiver, flow peer and general pin pads.
`timescale 1ns/10ps
module serial_peer (
  input wire logic clk,
  input wire logic ready,
  input wire logic [3:0] line_out,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe,
  input wire logic [15:0] ext_val,
  input wire logic [15:0] ext_oe,
  output logic [15:0] pad_in,
  output logic [3:0] cts_n,
  output logic [3:0] line_in
);
  // Pads have weak pull-downs, so a released pad reads low, never a stale level.
  assign pad_in = (pad_out & pad_oe) | (ext_val & ext_oe & ~pad_oe);
  initial begin
    cts_n = 4'hF;
    line_in = 4'hF;
  end
  // The peer answers a cycle late, which is slower than the design needs.
  always @(posedge clk) begin
    cts_n <= {4{~ready}};
    line_in <= line_out;
  end
endmodule // serial_peer

// *** verification/uart_pin_mux_bench.sv ***
// Self-checking bench of the pin function multiplexer.
`timescale 1ns/10ps
module uart_pin_mux_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, timer = 1'b0, ready = 1'b0, err, ph;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, irq;
  logic [15:0] pin_in, pin_out, pin_oe;
  logic [15:0] ext_val = 16'h0040; // Pin 6 held high, pin 7 driven low by the peer.
  logic [15:0] ext_oe = 16'h00C0;
  logic [3:0] clk_out = 4'h0, txd = 4'hF;
  logic [3:0] rxd, cts_sync, line_out, line_in, rts_n, cts_n;
  int bad_count = 0;
  int n_compared = 0;
  always #10 clk = ~clk;
  uart_pin_mux u_uart_pin_mux (.SYS_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .GPIO_IN(pin_in), .GPIO_OUT(pin_out), .GPIO_OE(pin_oe),
    .TIMER_OUT(timer), .UART_CLK_OUT(clk_out), .UART_TXD(txd), .UART_RXD(rxd),
    .UART_CTS_N(cts_sync), .SERIAL_OUT(line_out), .SERIAL_IN(line_in), .RTS_N(rts_n),
    .CTS_N(cts_n));
  serial_peer u_serial_peer (.clk(clk), .ready(ready), .line_out(line_out),
    .pad_out(pin_out), .pad_oe(pin_oe), .ext_val(ext_val), .ext_oe(ext_oe),
    .pad_in(pin_in), .cts_n(cts_n), .line_in(line_in));
  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim;
    $display("TB: %0d compared, %0d wrong", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rd, exp);
  endtask
  // Lets registered outputs land before they are looked at.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_regs;
    logic [7:0] a[9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h1C, 8'h20, 8'h24, 8'h30, 8'h40};
    cmp(rts_n, 4'hF);
    foreach (a[i]) rd_cmp(a[i], 32'h0000_0000);
    apb(1'b0, 8'h2C, 32'h0000_0000);
    cmp({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 8'h50, 32'hFFFF_FFFF);
    cmp(err, 1'b1);
  endtask
  // Pins 0 and 1 push-pull, 2 and 3 open drain, the rest inputs.
  task automatic t_gpio;
    apb(1'b1, 8'h00, 32'h0000_000F);
    apb(1'b1, 8'h04, 32'h0000_000C);
    apb(1'b1, 8'h08, 32'h0000_0005);
    settle(4);
    cmp({pin_oe, pin_out}, 32'h000B_0001);
    rd_cmp(8'h0C, 32'h0000_0041);
  endtask
  task automatic t_event;
    apb(1'b1, 8'h10, 32'h0000_0080);
    apb(1'b1, 8'h1C, 32'h0000_0080);
    @(posedge clk);
    ext_val[7] <= 1'b1;
    settle(6);
    cmp(irq, 1'b1);
    rd_cmp(8'h14, 32'h0000_0080);
    apb(1'b1, 8'h1C, 32'h0000_0000);
    settle(2);
    cmp(irq, 1'b0);
    apb(1'b1, 8'h18, 32'h0000_0080);
    rd_cmp(8'h14, 32'h0000_0000);
  endtask
  task automatic t_flow;
    @(posedge clk);
    ready <= 1'b1;
    settle(6);
    cmp(cts_sync, 4'h0);
    rd_cmp(8'h28, 32'h0000_00F0);
    rd_cmp(8'h14, 32'h000F_0000);
    apb(1'b1, 8'h18, 32'h000F_0000);
    for (int c = 0; c < 4; c++) apb(1'b1, 8'h40 + 8'(4 * c), 32'h0000_0002);
    settle(2);
    cmp(rts_n, 4'h0);
    @(posedge clk);
    clk_out <= 4'h4;
    apb(1'b1, 8'h38, 32'h0000_0080);
    settle(2);
    cmp(rts_n, 4'h4);
    @(posedge clk);
    clk_out <= 4'h0;
    settle(2);
    cmp(rts_n, 4'h0);
    @(posedge clk);
    clk_out <= 4'h4;
    apb(1'b1, 8'h38, 32'h0000_0000);
    settle(2);
    cmp(rts_n, 4'h0);
  endtask
  // Overrides take pins that are inputs, and hand them back when cleared.
  task automatic t_override;
    @(posedge clk);
    timer <= 1'b1;
    apb(1'b1, 8'h20, 32'h0000_0080);
    apb(1'b1, 8'h24, 32'h0000_0080);
    settle(2);
    cmp(pin_oe & 16'h3330, 16'h3330);
    cmp({pin_out[13], pin_out[9], pin_out[5]}, 3'b111);
    @(posedge clk);
    timer <= 1'b0;
    settle(2);
    cmp({pin_out[13], pin_out[9], pin_out[5]}, 3'b000);
    ph = pin_out[8];
    settle(2);
    cmp(pin_out[8], !ph);
    apb(1'b1, 8'h20, 32'h0000_0000);
    apb(1'b1, 8'h24, 32'h0000_0000);
    settle(2);
    cmp(pin_oe, 16'h000B);
    @(posedge clk);
    txd <= 4'hA;
    settle(6);
    cmp({line_out, rxd}, 8'hAA);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_gpio;
    t_event;
    t_flow;
    t_override;
    end_sim;
  end
  // Cuts a hang short well beyond the roughly 150 cycles the run needs.
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    end_sim;
  end
endmodule // uart_pin_mux_bench

// *** verification/uart_pin_mux_monitor.sv ***
// Port checker of the pin function multiplexer, bound to the top module.
`timescale 1ns/10ps
module uart_pin_mux_monitor (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PSLVERR,
  input wire logic IRQ,
  input wire logic [15:0] GPIO_OUT,
  input wire logic [15:0] GPIO_OE,
  input wire logic TIMER_OUT,
  input wire logic [3:0] UART_CLK_OUT,
  input wire logic [3:0] UART_TXD,
  input wire logic [3:0] UART_RXD,
  input wire logic [3:0] SERIAL_OUT,
  input wire logic [3:0] SERIAL_IN,
  input wire logic [3:0] RTS_N
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  logic wr; // A completed write transfer.
  logic ref_on, tmr_on, csel2, lc2; // Shadows of the override and level bits.
  assign wr = PSEL && PENABLE && PWRITE;
  // The shadows let the checks know which source a pin must carry.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      {ref_on, tmr_on, csel2, lc2} <= 4'h0;
    end else if (wr) begin
      if (PADDR == uart_pin_mux_pkg::ADDR_TX_SYNC_CONTROL) ref_on <= PWDATA[7];
      if (PADDR == uart_pin_mux_pkg::ADDR_TIMER_CONTROL_UPPER) tmr_on <= PWDATA[7];
      if (PADDR == 8'h38) csel2 <= PWDATA[7];
      if (PADDR == 8'h48) lc2 <= PWDATA[1];
    end
  end
  tx_pass_a: assert property (
    $past(RESETN) |-> SERIAL_OUT == $past(UART_TXD)) else $error("transmit pin lags wrongly");
  rx_sync_a: assert property (
    $past(RESETN) && $past(RESETN, 2) |-> UART_RXD == $past(SERIAL_IN, 2))
    else $error("receive data not synced");
  bad_addr_a: assert property (PSEL && PENABLE && (PADDR == 8'h2C || PADDR >= 8'h50)
    |-> PSLVERR) else $error("unmapped access without error");
  irq_mask_a: assert property (
    wr && PADDR == uart_pin_mux_pkg::ADDR_INT_ENABLE && PWDATA[19:0] == 20'h0_0000
    |-> ##2 !IRQ) else $error("interrupt not masked");
  ref_clk_a: assert property (
    $past(ref_on) && $past(ref_on, 3) |-> GPIO_OE[12] && GPIO_OUT[12] != $past(GPIO_OUT[12], 2))
    else $error("reference clock missing");
  timer_pin_a: assert property (
    $past(tmr_on) |-> GPIO_OE[9] && GPIO_OUT[9] == $past(TIMER_OUT)) else $error("timer missing");
  rts_clk_a: assert property (
    $past(csel2) |-> RTS_N[2] == $past(UART_CLK_OUT[2])) else $error("clock not on flow pin");
  rts_level_a: assert property (
    !$past(csel2) |-> RTS_N[2] == !$past(lc2)) else $error("flow pin level wrong");
  cover property (wr && PADDR == uart_pin_mux_pkg::ADDR_TX_SYNC_CONTROL && PWDATA[7]);
  cover property ($rose(IRQ));
  cover property (PSEL && PENABLE && PSLVERR);
endmodule // uart_pin_mux_monitor
bind uart_pin_mux uart_pin_mux_monitor u_uart_pin_mux_monitor (.*);
